/* File: hw/cpu_power_mode_control.sv */
// Purpose: Idle/Stop power mode control with reset wake, watchdog and
//    missing clock termination, and oscillator suspend wake-up.
// Assumes: instr_done pulses when the CPU retires an instruction; irq_enabled
//    is an enabled interrupt level on clk_sys; pins are asynchronous.
// Notes: APB slave, zero wait states, pslverr on unmapped addresses.
`timescale 1ns/1ps
module cpu_power_mode_control #(
   parameter int MCD_TIMEOUT = power_mode_pkg::MCD_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_done,
   input wire logic irq_enabled,
   input wire logic wdt_expire,
   input wire logic ext_rst_n,
   input wire logic usb_event,
   input wire logic vbus,
   output logic cpu_halt,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_run,
   output logic int_active,
   output logic reset_req,
   output logic [15:0] reset_vector,
   output logic resume_next
);
   typedef enum logic [1:0] {RUN, IDLE, STOP} mode_t;

   typedef struct packed {
      mode_t mode;
      logic idle_arm;
      logic stop_arm;
      logic [5:0] flags;
      logic wdt_en;
      logic mcd_en;
      logic suspend;
      logic vbus_pol;
      logic [power_mode_pkg::MCD_CNT_W-1:0] mcd_cnt;
      logic [1:0] ext_sync;
      logic [1:0] vbus_sync;
      logic [1:0] usb_sync;
      logic reset_req;
      logic resume;
      logic [31:0] prdata;
      logic pslverr;
   } state_t;

   localparam int CNT_W = power_mode_pkg::MCD_CNT_W;
   localparam logic [CNT_W-1:0] MCD_LAST = CNT_W'(MCD_TIMEOUT - 1);

   state_t st;
   state_t next_st;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == power_mode_pkg::PMC_ADDR) || (a == power_mode_pkg::CTRL_ADDR) ||
         (a == power_mode_pkg::STATUS_ADDR);
   endfunction : mapped

   function automatic logic [1:0] mode_code(input mode_t m);
      unique case (m)
         RUN: mode_code = power_mode_pkg::MODE_CODE_RUN;
         IDLE: mode_code = power_mode_pkg::MODE_CODE_IDLE;
         STOP: mode_code = power_mode_pkg::MODE_CODE_STOP;
         default: mode_code = power_mode_pkg::MODE_CODE_RUN;
      endcase
   endfunction : mode_code

   logic setup;
   logic wr_access;
   logic wr_pmc;
   logic wr_ctrl;
   logic idle_req;
   logic stop_req;
   logic ext_reset;
   logic wdt_reset;
   logic mcd_reset;
   logic any_reset;
   logic osc_wake;

   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign wr_pmc = wr_access && (paddr == power_mode_pkg::PMC_ADDR);
   assign wr_ctrl = wr_access && (paddr == power_mode_pkg::CTRL_ADDR);
   // A write in the same cycle as instr_done still counts for that instruction
   assign idle_req = st.idle_arm || (wr_pmc && pwdata[power_mode_pkg::IDLE_BIT]);
   assign stop_req = st.stop_arm || (wr_pmc && pwdata[power_mode_pkg::STOP_BIT]);
   assign ext_reset = !st.ext_sync[1];
   assign wdt_reset = st.wdt_en && wdt_expire;
   assign mcd_reset = (st.mode == STOP) && st.mcd_en && (st.mcd_cnt == MCD_LAST);
   assign any_reset = ext_reset || wdt_reset || mcd_reset;
   assign osc_wake = st.usb_sync[1] || (st.vbus_sync[1] == st.vbus_pol);

   always_comb begin
      next_st = st;
      next_st.ext_sync = {st.ext_sync[0], ext_rst_n};
      next_st.vbus_sync = {st.vbus_sync[0], vbus};
      next_st.usb_sync = {st.usb_sync[0], usb_event};
      next_st.reset_req = 1'b0;
      next_st.resume = 1'b0;

      // Read data captured in setup so it stands through the access phase
      if (setup) begin
         next_st.pslverr = !mapped(paddr);
         next_st.prdata = 32'h0;
         if (paddr == power_mode_pkg::PMC_ADDR) begin
            // Mode select bits always read back as zero
            next_st.prdata[7:power_mode_pkg::FLAGS_LSB] = st.flags;
         end else if (paddr == power_mode_pkg::CTRL_ADDR) begin
            next_st.prdata[power_mode_pkg::CTRL_WDT_EN_BIT] = st.wdt_en;
            next_st.prdata[power_mode_pkg::CTRL_MCD_EN_BIT] = st.mcd_en;
            next_st.prdata[power_mode_pkg::CTRL_SUSPEND_BIT] = st.suspend;
            next_st.prdata[power_mode_pkg::CTRL_VBUS_POL_BIT] = st.vbus_pol;
         end else if (paddr == power_mode_pkg::STATUS_ADDR) begin
            next_st.prdata[1:0] = mode_code(st.mode);
            next_st.prdata[power_mode_pkg::STAT_SUSPEND_BIT] = st.suspend;
            next_st.prdata[power_mode_pkg::STAT_OSC_BIT] = osc_run;
         end
      end

      if (wr_pmc) begin
         next_st.flags = pwdata[7:power_mode_pkg::FLAGS_LSB];
      end
      if (wr_ctrl) begin
         next_st.wdt_en = pwdata[power_mode_pkg::CTRL_WDT_EN_BIT];
         next_st.mcd_en = pwdata[power_mode_pkg::CTRL_MCD_EN_BIT];
         next_st.vbus_pol = pwdata[power_mode_pkg::CTRL_VBUS_POL_BIT];
      end

      // Suspend: software sets, wake clears; a set in the wake cycle wins
      if (wr_ctrl && pwdata[power_mode_pkg::CTRL_SUSPEND_BIT]) begin
         next_st.suspend = 1'b1;
      end else if (wr_ctrl) begin
         next_st.suspend = 1'b0;
      end else if (st.suspend && osc_wake) begin
         next_st.suspend = 1'b0;
      end

      next_st.mcd_cnt = '0;
      if (any_reset) begin
         // Reset wakes from any mode and restarts the CPU at the vector
         next_st.mode = RUN;
         next_st.idle_arm = 1'b0;
         next_st.stop_arm = 1'b0;
         next_st.reset_req = 1'b1;
      end else begin
         unique case (st.mode)
            RUN: begin
               next_st.idle_arm = idle_req;
               next_st.stop_arm = stop_req;
               if (instr_done && stop_req) begin
                  next_st.mode = STOP;
                  next_st.idle_arm = 1'b0;
                  next_st.stop_arm = 1'b0;
               end else if (instr_done && idle_req) begin
                  next_st.mode = IDLE;
                  next_st.idle_arm = 1'b0;
               end
            end
            IDLE: begin
               // Flags untouched by hardware here
               if (irq_enabled) begin
                  next_st.mode = RUN;
                  next_st.resume = 1'b1;
               end
            end
            STOP: begin
               // Interrupts are ignored; only a reset leaves Stop
               if (st.mcd_en) begin
                  next_st.mcd_cnt = st.mcd_cnt + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{mode: RUN, idle_arm: 1'b0, stop_arm: 1'b0,
            flags: power_mode_pkg::PMC_RESET[7:2],
            wdt_en: power_mode_pkg::CTRL_RESET[0], mcd_en: power_mode_pkg::CTRL_RESET[1],
            suspend: power_mode_pkg::CTRL_RESET[2], vbus_pol: power_mode_pkg::CTRL_RESET[3],
            mcd_cnt: '0, ext_sync: 2'h3, vbus_sync: 2'h0, usb_sync: 2'h0,
            reset_req: 1'b0, resume: 1'b0, prdata: 32'h0, pslverr: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = 1'b1;
   assign pslverr = st.pslverr;
   assign cpu_halt = (st.mode != RUN);
   assign cpu_clk_en = (st.mode == RUN);
   assign periph_clk_en = (st.mode != STOP);
   assign osc_run = (st.mode != STOP) && !st.suspend;
   assign int_active = (st.mode != STOP);
   assign reset_req = st.reset_req;
   assign reset_vector = power_mode_pkg::RESET_VECTOR;
   assign resume_next = st.resume;

   sequence idle_written;
      idle_req && !stop_req &&
         st.mode == RUN;
   endsequence
   sequence quiet_retire;
      instr_done && !any_reset;
   endsequence

   idle_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      idle_written ##0 quiet_retire |=> st.mode == IDLE && cpu_halt)
      else $error("Idle not entered after retiring write");

   stop_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == RUN && stop_req && instr_done && !any_reset) |=> st.mode == STOP)
      else $error("Stop not entered after retiring write");

   idle_clocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st.mode == IDLE |-> cpu_halt && !cpu_clk_en && periph_clk_en && int_active)
      else $error("Idle clocking wrong");

   stop_halts_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st.mode == STOP |-> !osc_run && !periph_clk_en && !int_active && cpu_halt)
      else $error("Stop did not halt");

   idle_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == IDLE && irq_enabled && !any_reset) |=> st.mode == RUN && resume_next
         ##1 !resume_next)
      else $error("Interrupt wake from idle wrong");

   idle_retain_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == IDLE && !wr_pmc) |=> $stable(st.flags))
      else $error("Idle lost register contents");

   ext_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(ext_rst_n) |-> ##3 reset_req && st.mode == RUN && reset_vector == 16'h0000)
      else $error("External reset did not restart");

   wdt_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == IDLE && st.wdt_en && wdt_expire) |=> reset_req && st.mode == RUN)
      else $error("Watchdog did not end idle");

   stop_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == STOP && !any_reset) |=> st.mode == STOP)
      else $error("Stop left without reset");

   mcd_timeout_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == STOP && st.mcd_en && st.mcd_cnt == MCD_LAST) |=> reset_req ##0
         st.mode == RUN)
      else $error("Missing clock timeout did not reset");

   osc_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.suspend && !osc_wake && !wr_ctrl) |=> st.suspend && !osc_run)
      else $error("Oscillator left suspend without cause");

   run_clocks_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st.mode == RUN |-> !cpu_halt && cpu_clk_en && periph_clk_en && int_active)
      else $error("Run clocking wrong");

   stop_irq_ignored_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == STOP && irq_enabled && !any_reset) |=> st.mode == STOP && !resume_next)
      else $error("Interrupt acted in stop");

   wdt_masked_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == IDLE && !st.wdt_en && wdt_expire && !any_reset && !irq_enabled) |=>
         st.mode == IDLE && !reset_req)
      else $error("Disabled watchdog ended idle");

   reset_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_reset |=> reset_req && st.mode == RUN && !st.idle_arm && !st.stop_arm)
      else $error("Reset did not restart");

   reset_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reset_req |-> reset_vector == power_mode_pkg::RESET_VECTOR)
      else $error("Reset vector wrong");

   flags_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_pmc |=> $stable(st.flags))
      else $error("Flags changed without write");

   flags_inert_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_pmc && !pwdata[power_mode_pkg::IDLE_BIT] && !pwdata[power_mode_pkg::STOP_BIT] &&
         st.mode == RUN && !st.idle_arm && !st.stop_arm) |=> st.mode == RUN &&
         !st.idle_arm && !st.stop_arm)
      else $error("Flag write changed mode");

   idle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == IDLE && !irq_enabled && !any_reset) |=> st.mode == IDLE)
      else $error("Idle left without cause");

   resume_source_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      resume_next |-> st.mode == RUN && $past(st.mode) == IDLE)
      else $error("Resume without idle wake");

   idle_arm_kept_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == RUN && st.idle_arm && !instr_done && !any_reset) |=>
         st.idle_arm && st.mode == RUN)
      else $error("Idle entered before retire");

   mcd_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == STOP && st.mcd_en && !any_reset) |=> st.mcd_cnt == $past(st.mcd_cnt) + 1'b1)
      else $error("Missing clock count stalled");

   mcd_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == STOP && !st.mcd_en) |=> st.mcd_cnt == '0)
      else $error("Disabled detector counted");

   suspend_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_ctrl && pwdata[power_mode_pkg::CTRL_SUSPEND_BIT]) |=> st.suspend && !osc_run)
      else $error("Suspend not entered");

   suspend_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.suspend && osc_wake && !wr_ctrl) |=> !st.suspend)
      else $error("Suspend not left on wake");

   pmc_readback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (setup && paddr == power_mode_pkg::PMC_ADDR) |=>
         prdata == {24'h0, $past(st.flags), 2'b00})
      else $error("Power control read wrong");

   unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (setup && !mapped(paddr)) |=> pslverr && prdata == 32'h0)
      else $error("Unmapped access not refused");

   wake_clears_arm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st.mode == IDLE && irq_enabled && !any_reset) |=> !st.idle_arm && !st.stop_arm)
      else $error("Idle select left armed");
endmodule : cpu_power_mode_control

/* File: hw/power_mode_pkg.sv */
// Purpose: Shared constants for the CPU power mode controller.
// Assumes: APB word addressing; 100 MHz clk_sys.
// Notes: Register index 0x87 is not word aligned, so byte address = 4 * index.
package power_mode_pkg;
   // Register indices and byte addresses
   localparam logic [11:0] PMC_INDEX = 12'h087;
   localparam logic [11:0] PMC_ADDR = 12'h21c;
   localparam logic [11:0] CTRL_ADDR = 12'h200;
   localparam logic [11:0] STATUS_ADDR = 12'h204;

   // power_mode_control fields
   localparam int IDLE_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int FLAGS_LSB = 2;
   localparam logic [7:0] PMC_RESET = 8'h00;

   // Control register fields
   localparam int CTRL_WDT_EN_BIT = 0;
   localparam int CTRL_MCD_EN_BIT = 1;
   localparam int CTRL_SUSPEND_BIT = 2;
   localparam int CTRL_VBUS_POL_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h3;

   // Status register fields and mode codes
   localparam int STAT_SUSPEND_BIT = 2;
   localparam int STAT_OSC_BIT = 3;
   localparam logic [1:0] MODE_CODE_RUN = 2'h0;
   localparam logic [1:0] MODE_CODE_IDLE = 2'h1;
   localparam logic [1:0] MODE_CODE_STOP = 2'h2;

   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // Missing clock detector timeout
   localparam int CLK_PERIOD_NS = 10;
   localparam int MCD_TIMEOUT_NS = 100000;
   localparam int MCD_TIMEOUT_CYC = MCD_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int MCD_CNT_W = 14;
endpackage : power_mode_pkg

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the CPU power mode controller.
// Assumes: zero wait state APB slave; missing clock timeout shortened to 20.
// Notes: all expectations come from package constants and the bench's own figures.
`timescale 1ns/1ps
module tb;
   localparam int MCD_T = 20;
   localparam logic [11:0] PMC = power_mode_pkg::PMC_ADDR;
   localparam logic [11:0] CTL = power_mode_pkg::CTRL_ADDR;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic instr_done = 1'b0;
   logic irq_enabled = 1'b0;
   logic wdt_expire = 1'b0;
   logic ext_rst_n = 1'b1;
   logic usb_event = 1'b0;
   logic vbus = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, cpu_halt, cpu_clk_en, periph_clk_en, osc_run;
   logic int_active, reset_req, resume_next;
   logic [15:0] reset_vector;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;

   always #5 clk_sys = ~clk_sys;

   cpu_power_mode_control #(.MCD_TIMEOUT(MCD_T)) cpu_power_mode_control_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_done(instr_done), .irq_enabled(irq_enabled), .wdt_expire(wdt_expire),
      .ext_rst_n(ext_rst_n), .usb_event(usb_event), .vbus(vbus), .cpu_halt(cpu_halt),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
      .int_active(int_active), .reset_req(reset_req), .reset_vector(reset_vector),
      .resume_next(resume_next));

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Request held until pready is seen high; data taken at that same edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : tick

   // One-cycle pulse: 0 retire, 1 interrupt, 2 watchdog expiry
   task automatic pulse(input int k);
      @(posedge clk_sys);
      if (k == 0) instr_done <= 1'b1;
      else if (k == 1) irq_enabled <= 1'b1;
      else wdt_expire <= 1'b1;
      @(posedge clk_sys);
      instr_done <= 1'b0;
      irq_enabled <= 1'b0;
      wdt_expire <= 1'b0;
      #1;
   endtask : pulse

   task automatic wait_req(input int lim);
      n = 0;
      while (reset_req !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
   endtask : wait_req

   task automatic test_regs;
      apb(0, PMC, 0);
      chk("pmc reset", power_mode_pkg::PMC_RESET, rd);
      apb(0, CTL, 0);
      chk("ctrl reset", power_mode_pkg::CTRL_RESET, rd);
      apb(1, PMC, 32'h0000_00fc);
      apb(0, PMC, 0);
      chk("flags", 32'h0000_00fc, rd);
      pulse(0);
      chk("flags no halt", 0, cpu_halt);
      apb(0, 12'h3f0, 0);
      chk("unmapped err", 1, err);
      chk("pready", 1, pready);
      $display("test regs done");
   endtask : test_regs

   task automatic test_idle;
      apb(1, PMC, 32'h0000_00a5);
      tick(0);
      chk("halt before retire", 0, cpu_halt);
      pulse(0);
      chk("idle halt", 1, cpu_halt);
      chk("idle cpu clk", 0, cpu_clk_en);
      chk("idle periph clk", 1, periph_clk_en);
      chk("idle osc", 1, osc_run);
      chk("idle irq live", 1, int_active);
      apb(0, power_mode_pkg::STATUS_ADDR, 0);
      chk("idle status", {28'h0, 2'b10, power_mode_pkg::MODE_CODE_IDLE}, rd);
      apb(0, PMC, 0);
      chk("idle keeps flags", 32'h0000_00a4, rd);
      pulse(1);
      chk("wake halt", 0, cpu_halt);
      chk("wake cpu clk", 1, cpu_clk_en);
      chk("resume pulse", 1, resume_next);
      tick(1);
      chk("resume once", 0, resume_next);
      apb(0, PMC, 0);
      chk("idle bit cleared", 32'h0000_00a4, rd);
      pulse(0);
      chk("no second idle", 0, cpu_halt);
      $display("test idle done");
   endtask : test_idle

   task automatic test_wdt;
      for (int en = 0; en < 2; en++) begin
         apb(1, CTL, {30'h0, 1'b1, en[0]});
         apb(1, PMC, 32'h0000_0001);
         pulse(0);
         pulse(2);
         wait_req(4);
         chk("wdt reset", en, reset_req);
         tick(2);
         chk("wdt ends idle", en, !cpu_halt);
      end
      chk("vector", power_mode_pkg::RESET_VECTOR, reset_vector);
      $display("test watchdog done");
   endtask : test_wdt

   task automatic test_stop;
      apb(1, PMC, 32'h0000_0002);
      pulse(0);
      chk("stop halt", 1, cpu_halt);
      chk("stop osc", 0, osc_run);
      chk("stop periph", 0, periph_clk_en);
      chk("stop irq off", 0, int_active);
      pulse(1);
      chk("irq no wake", 1, cpu_halt);
      wait_req(MCD_T + 5);
      chk("mcd span", MCD_T, n + 2);
      tick(1);
      chk("mcd ends stop", 0, cpu_halt);
      apb(1, CTL, 32'h0000_0001);
      apb(1, PMC, 32'h0000_0002);
      pulse(0);
      tick(MCD_T + 10);
      chk("mcd off holds", 1, cpu_halt);
      apb(0, power_mode_pkg::STATUS_ADDR, 0);
      chk("stop status", {30'h0, power_mode_pkg::MODE_CODE_STOP}, rd);
      @(posedge clk_sys);
      ext_rst_n <= 1'b0;
      wait_req(6);
      chk("ext reset", 1, reset_req);
      @(posedge clk_sys);
      ext_rst_n <= 1'b1;
      tick(4);
      chk("ext ends stop", 0, cpu_halt);
      $display("test stop done");
   endtask : test_stop

   task automatic test_suspend;
      for (int k = 0; k < 2; k++) begin
         apb(1, CTL, 32'h0000_000d);
         tick(6);
         chk("suspended", 0, osc_run);
         @(posedge clk_sys);
         if (k == 0) usb_event <= 1'b1;
         else vbus <= 1'b1;
         n = 0;
         while (osc_run !== 1'b1 && n < 8) begin
            tick(1);
            n++;
         end
         chk("osc woke", 1, osc_run);
         @(posedge clk_sys);
         usb_event <= 1'b0;
         apb(0, CTL, 0);
         chk("wake clears suspend", 32'h0000_0009, rd);
      end
      $display("test suspend done");
   endtask : test_suspend

   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      test_regs();
      test_idle();
      test_wdt();
      test_stop();
      test_suspend();
      complete_run();
   end
endmodule : tb
